// ==== txbb_map.vh ====
// register offsets, field positions and timing constants of the tx modulator
// How it works
// - all logic runs on the baseband sample clock
// - modulation runs only while active bit set
// - nine-bit i/q from quarter-wave table lookup
// - 4096 steps per period, offset times four
// - fsk deviation equals ram word per step
// - 64-byte modulation ram, six-bit span setting
// - span entries per half bit, divider clocks per entry
// - fsk increment is ram word plus four offset
// - polarity bit swaps i and q sideband
// - mode bit one selects ask, zero fsk
// - power bit 7 switches pa supply, resets zero
// - pre-amp current bits 5 and 0
// - write-only eight-bit bias register resets zero
// - feedback divider 16 or 22 by band
// - band bit zero selects 22, resets one
// - bit rate half clock over divider times span
// - busy flag zero means load next byte
// - ram writable only while access bit set
`ifndef TXBB_MAP_VH
`define TXBB_MAP_VH
`define TXBB_ADR_RAM_DATA 8'hc9
`define TXBB_ADR_RAM_SPAN 8'hca
`define TXBB_ADR_TX_DATA 8'hcb
`define TXBB_ADR_BAND 8'hc2
`define TXBB_ADR_OFFSET 8'hd1
`define TXBB_ADR_SCALE 8'hd2
`define TXBB_ADR_CONTROL 8'hd3
`define TXBB_ADR_STATE 8'heb
`define TXBB_ADR_PA_POWER 8'hf1
`define TXBB_ADR_PA_BIAS 8'hf2
`define TXBB_CTL_POLARITY 5
`define TXBB_CTL_ENABLE 4
`define TXBB_CTL_ASK 3
`define TXBB_CTL_RAM_ACCESS 2
`define TXBB_CTL_SHIFT 1
`define TXBB_PA_SUPPLY 7
`define TXBB_PA_CUR_HI 5
`define TXBB_PA_CUR_LO 0
`define TXBB_PA_RESET 8'h00
`define TXBB_BIAS_RESET 8'h00
`define TXBB_BAND_RESET 8'h80
`define TXBB_DIV_LOW_BAND 5'h10
`define TXBB_DIV_HIGH_BAND 5'h16
`define TXBB_STATE_RESERVED 8'h40
`endif

// ==== txbb_sine_rom.v ====
// quarter-wave sine table with quadrant mirroring and sign
`timescale 1ns/1ps
module txbb_sine_rom (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // phase in, sample out
  input wire [11:0] phase_i,
  output reg [8:0] sample_o
);
  // 128-entry quarter table, generated as a constant function
  function [7:0] quarter_sin;
    input [6:0] idx;
    reg [15:0] prod;
    begin
      // parabola approximation of sin over one quarter, 0..255
      // product kept at 16 bits: it reaches 14 bits near the peak
      prod = {9'h000, idx} * (16'h0100 - {9'h000, idx});
      quarter_sin = prod[13:6];
    end
  endfunction
  reg [6:0] idx;
  reg [7:0] mag;
  // quadrant from top bits, mirror index in odd quadrants
  always @* begin
    idx = phase_i[10] ? ~phase_i[9:3] : phase_i[9:3];
    mag = quarter_sin(idx);
  end
  // negate in the second half-period, nine-bit signed out
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      sample_o <= 9'h000;
    end else begin
      sample_o <= phase_i[11] ? (9'h000 - {1'b0, mag}) : {1'b0, mag};
    end
  end
endmodule // txbb_sine_rom

// ==== txbb_bit_timer.v ====
// ram sweep timer: divider clocks per entry, span entries per half bit
`timescale 1ns/1ps
module txbb_bit_timer (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // settings
  input wire run_i,
  input wire [7:0] scale_i,
  input wire [5:0] span_i,
  // position out
  output reg [5:0] addr_o,
  output reg half_bit_o
);
  reg [7:0] div_r;
  // each entry lasts scale clocks, span entries make half a bit
  always @(posedge clk_sys_i) begin
    if (reset_i || !run_i) begin
      div_r <= 8'h00;
      addr_o <= 6'h00;
      half_bit_o <= 1'b0;
    end else begin
      half_bit_o <= 1'b0;
      if (div_r + 8'h01 >= scale_i) begin
        div_r <= 8'h00;
        if (addr_o + 6'h01 >= span_i) begin
          addr_o <= 6'h00;
          half_bit_o <= 1'b1;
        end else begin
          addr_o <= addr_o + 6'h01;
        end
      end else begin
        div_r <= div_r + 8'h01;
      end
    end
  end
endmodule // txbb_bit_timer

// ==== txbb_modulator.v ====
// baseband i/q modulator with pa control and sfr port
`timescale 1ns/1ps
`include "txbb_map.vh"
module txbb_modulator (
  // clock and reset: baseband sample clock
  input wire clk_sys_i,
  input wire reset_i,
  // sfr write/read port
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  output reg [7:0] sfr_rdata_o,
  // dac samples
  output reg [8:0] i_sample_o,
  output reg [8:0] q_sample_o,
  // pa and synthesiser controls
  output reg pa_supply_on_o,
  output reg [1:0] pre_amp_current_o,
  output reg [7:0] pa_output_bias_o,
  output reg [4:0] fb_divider_o,
  output reg tx_bit_o,
  output reg ask_gate_o
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [7:0] ram [0:63];
  reg [7:0] offset_r, scale_r, ctrl_r, band_r, pa_power_r, pa_bias_r;
  reg [7:0] tx_data_r, shift_r;
  reg [5:0] span_r;
  reg busy_r, half_sel_r;
  reg [2:0] bit_cnt_r;
  reg [11:0] acc_r;
  reg [7:0] ram_word;
  reg [11:0] step;
  wire run = ctrl_r[`TXBB_CTL_ENABLE];
  wire ask = ctrl_r[`TXBB_CTL_ASK];
  wire [5:0] ram_addr;
  wire half_bit;
  wire [8:0] sin_s, cos_s;

  // true when a strobe targets the given register address
  function reg_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] target;
    begin
      reg_hit = strobe && (addr == target);
    end
  endfunction

  // decoded strobes, each used in one process
  wire tx_data_wr = reg_hit(sfr_wr_i, sfr_addr_i, `TXBB_ADR_TX_DATA);
  wire ram_data_wr = reg_hit(sfr_wr_i, sfr_addr_i, `TXBB_ADR_RAM_DATA);
  wire state_rd = reg_hit(sfr_rd_i, sfr_addr_i, `TXBB_ADR_STATE);

  // modulation settings; unwritten settings start at zero
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      offset_r <= 8'h00;
      scale_r <= 8'h00;
      ctrl_r <= 8'h00;
      span_r <= 6'h00;
      tx_data_r <= 8'h00;
    end else if (sfr_wr_i) begin
      case (sfr_addr_i)
        `TXBB_ADR_OFFSET: offset_r <= sfr_wdata_i;
        `TXBB_ADR_SCALE: scale_r <= sfr_wdata_i;
        `TXBB_ADR_CONTROL: ctrl_r <= sfr_wdata_i & 8'hbe;
        `TXBB_ADR_RAM_SPAN: span_r <= sfr_wdata_i[5:0];
        `TXBB_ADR_TX_DATA: tx_data_r <= sfr_wdata_i;
        default: ;
      endcase
    end
  end

  // band select keeps bit 7 only and resets to divide-by-16
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      band_r <= `TXBB_BAND_RESET;
    end else if (reg_hit(sfr_wr_i, sfr_addr_i, `TXBB_ADR_BAND)) begin
      band_r <= sfr_wdata_i & 8'h80;
    end
  end

  // pa registers are write-only and reset to zero
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      pa_power_r <= `TXBB_PA_RESET;
      pa_bias_r <= `TXBB_BIAS_RESET;
    end else begin
      if (reg_hit(sfr_wr_i, sfr_addr_i, `TXBB_ADR_PA_POWER)) begin
        pa_power_r <= sfr_wdata_i;
      end
      if (reg_hit(sfr_wr_i, sfr_addr_i, `TXBB_ADR_PA_BIAS)) begin
        pa_bias_r <= sfr_wdata_i;
      end
    end
  end

  // ram write: data lands at span address only in access mode
  // the ram has no reset; software must fill it before fsk use
  always @(posedge clk_sys_i) begin
    if (ram_data_wr && ctrl_r[`TXBB_CTL_RAM_ACCESS]) begin
      ram[span_r] <= sfr_wdata_i;
    end
  end

  // ---------------------------------------------------------------
  // phase generator
  // ---------------------------------------------------------------
  // sweep ram while modulating, not while software owns it
  txbb_bit_timer u_timer (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .run_i(run && !ctrl_r[`TXBB_CTL_RAM_ACCESS]),
    .scale_i(scale_r),
    .span_i(span_r),
    .addr_o(ram_addr),
    .half_bit_o(half_bit)
  );

  // fsk adds ram word to four times offset; ask uses offset alone
  always @* begin
    ram_word = ram[ram_addr];
    if (ask) begin
      step = {2'b00, offset_r, 2'b00};
    end else begin
      step = {2'b00, offset_r, 2'b00} + {4'h0, ram_word};
    end
  end

  // 12-bit accumulator wraps modulo 4096
  always @(posedge clk_sys_i) begin
    if (reset_i || !run) begin
      acc_r <= 12'h000;
    end else begin
      acc_r <= acc_r + step;
    end
  end

  // cosine is sine a quarter period ahead
  txbb_sine_rom u_sin (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .phase_i(acc_r),
    .sample_o(sin_s)
  );
  txbb_sine_rom u_cos (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .phase_i(acc_r + 12'h400),
    .sample_o(cos_s)
  );

  // ---------------------------------------------------------------
  // byte shifter and busy
  // ---------------------------------------------------------------
  // end of the eighth bit, where a pending byte moves to the shifter
  wire byte_end = ctrl_r[`TXBB_CTL_SHIFT] && run && half_bit &&
                  half_sel_r && (bit_cnt_r == 3'h7);

  // two half-bit sweeps per bit; msb first
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      shift_r <= 8'h00;
      half_sel_r <= 1'b0;
      bit_cnt_r <= 3'h0;
    end else if (!ctrl_r[`TXBB_CTL_SHIFT] || !run) begin
      half_sel_r <= 1'b0;
      bit_cnt_r <= 3'h0;
    end else if (half_bit) begin
      half_sel_r <= !half_sel_r;
      if (half_sel_r) begin
        if (bit_cnt_r == 3'h7) begin
          bit_cnt_r <= 3'h0;
          // with nothing pending the last bit simply holds
          if (busy_r) begin
            shift_r <= tx_data_r;
          end
        end else begin
          bit_cnt_r <= bit_cnt_r + 3'h1;
          shift_r <= {shift_r[6:0], 1'b0};
        end
      end
    end
  end

  // busy from a buffer write until the byte is taken; a write in the
  // same cycle as the take wins, so the new byte stays pending
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      busy_r <= 1'b0;
    end else if (tx_data_wr) begin
      busy_r <= 1'b1;
    end else if (byte_end) begin
      busy_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // dac samples, zero while idle; polarity swaps i and q
  always @(posedge clk_sys_i) begin
    if (reset_i || !run) begin
      i_sample_o <= 9'h000;
      q_sample_o <= 9'h000;
    end else if (ctrl_r[`TXBB_CTL_POLARITY]) begin
      i_sample_o <= sin_s;
      q_sample_o <= cos_s;
    end else begin
      i_sample_o <= cos_s;
      q_sample_o <= sin_s;
    end
  end

  // pa supply switch, pre-amp current and output bias
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      pa_supply_on_o <= 1'b0;
      pre_amp_current_o <= 2'b00;
      pa_output_bias_o <= 8'h00;
    end else begin
      pa_supply_on_o <= pa_power_r[`TXBB_PA_SUPPLY];
      pre_amp_current_o <= {pa_power_r[`TXBB_PA_CUR_HI],
                            pa_power_r[`TXBB_PA_CUR_LO]};
      pa_output_bias_o <= pa_bias_r;
    end
  end

  // feedback divider ratio follows the band bit
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      fb_divider_o <= `TXBB_DIV_LOW_BAND;
    end else begin
      fb_divider_o <= band_r[7] ? `TXBB_DIV_LOW_BAND
                                : `TXBB_DIV_HIGH_BAND;
    end
  end

  // current data bit, and the amplitude gate that carries it in ask
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      tx_bit_o <= 1'b0;
      ask_gate_o <= 1'b0;
    end else begin
      tx_bit_o <= shift_r[7];
      ask_gate_o <= run && ask && shift_r[7];
    end
  end

  // only the state register reads back; others are write-only
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (state_rd) begin
      sfr_rdata_o <= {busy_r, 7'h00} | `TXBB_STATE_RESERVED;
    end else begin
      sfr_rdata_o <= 8'h00;
    end
  end
endmodule // txbb_modulator

// ==== txbb_modulator_properties.sv ====
// port assertions for the tx baseband modulator
`timescale 1ns/1ps
module txbb_modulator_properties (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // sfr port
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire [7:0] sfr_rdata_o,
  // samples and controls
  input wire [8:0] i_sample_o,
  input wire [8:0] q_sample_o,
  input wire pa_supply_on_o,
  input wire [1:0] pre_amp_current_o,
  input wire [7:0] pa_output_bias_o,
  input wire [4:0] fb_divider_o,
  input wire tx_bit_o,
  input wire ask_gate_o
);
  // ----------------------------------------
  // helpers and properties
  // ----------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  logic en_r;
  logic [7:0] d1_r, d2_r;
  wire [7:0] a = sfr_addr_i;
  // enable bit and write data two edges back
  always @(posedge clk_sys_i) begin
    d1_r <= sfr_wdata_i;
    d2_r <= d1_r;
    if (reset_i) en_r <= 1'b0;
    else if (sfr_wr_i && a == 8'hd3) en_r <= sfr_wdata_i[4];
  end
  AST_RESET: assert property ($fell(reset_i) |->
    !pa_supply_on_o && fb_divider_o == 5'h10) else $error("reset value");
  AST_PA_SUPPLY: assert property (sfr_wr_i && a == 8'hf1 |->
    ##2 pa_supply_on_o == d2_r[7]) else $error("pa supply");
  AST_PRE_AMP: assert property (sfr_wr_i && a == 8'hf1 |->
    ##2 pre_amp_current_o == {d2_r[5], d2_r[0]}) else $error("pre amp");
  AST_BIAS: assert property (sfr_wr_i && a == 8'hf2 |->
    ##2 pa_output_bias_o == d2_r) else $error("bias");
  AST_BAND: assert property (sfr_wr_i && a == 8'hc2 |->
    ##2 fb_divider_o == (d2_r[7] ? 5'h10 : 5'h16)) else $error("band");
  AST_IDLE: assert property (!en_r [*6] |->
    i_sample_o == 9'h000 && q_sample_o == 9'h000) else $error("idle");
  AST_RD_IDLE: assert property (!sfr_rd_i |=>
    sfr_rdata_o == 8'h00) else $error("read idle");
  AST_STATE: assert property (sfr_rd_i && a == 8'heb |=>
    sfr_rdata_o[6:0] == 7'h40) else $error("state read");
  AST_UNMAPPED: assert property (sfr_rd_i && a == 8'h00 |=>
    sfr_rdata_o == 8'h00) else $error("unmapped read");
  AST_ASK_GATE: assert property (ask_gate_o |-> tx_bit_o)
    else $error("ask gate without data bit");
  cover property (ask_gate_o);
  cover property (sfr_wr_i && a == 8'hf1);
  cover property (en_r [*8]);
  cover property (sfr_rd_i && a == 8'heb);
endmodule // txbb_modulator_properties
bind txbb_modulator txbb_modulator_properties txbb_modulator_properties_i (
  .clk_sys_i, .reset_i, .sfr_wr_i, .sfr_rd_i, .sfr_addr_i, .sfr_wdata_i,
  .sfr_rdata_o, .i_sample_o, .q_sample_o, .pa_supply_on_o,
  .pre_amp_current_o, .pa_output_bias_o, .fb_divider_o, .tx_bit_o,
  .ask_gate_o);

// ==== txbb_dac_model.sv ====
// behavioural model of the i/q dac pair
`timescale 1ns/1ps
module txbb_dac_model (
  // clock
  input wire clk_sys_i,
  // samples in
  input wire [8:0] i_sample_i,
  input wire [8:0] q_sample_i,
  // analog activity out
  output reg active_o
);
  // ----------------------------------------
  // conversion
  // ----------------------------------------
  // converts each sample clock; zero code is no signal
  always @(posedge clk_sys_i) begin
    active_o <= (i_sample_i != 9'h000) || (q_sample_i != 9'h000);
  end
endmodule // txbb_dac_model

// ==== tb_txbb_modulator.sv ====
// testbench for the tx baseband modulator
`timescale 1ns/1ps
module tb_txbb_modulator;
  logic clk_sys_i, reset_i, sfr_wr_i, sfr_rd_i, pa_supply_on_o;
  logic tx_bit_o, ask_gate_o, active;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, pa_output_bias_o, rd;
  logic [8:0] i_sample_o, q_sample_o;
  logic [8:0] iw [0:16];
  logic [8:0] qw [0:16];
  logic [1:0] pre_amp_current_o;
  logic [4:0] fb_divider_o;
  int mismatches, num_checks;
  // ----------------------------------------
  // design, dac model, clock, tasks
  // ----------------------------------------
  txbb_modulator txbb_modulator_i (.clk_sys_i, .reset_i, .sfr_wr_i,
    .sfr_rd_i, .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o, .i_sample_o,
    .q_sample_o, .pa_supply_on_o, .pre_amp_current_o, .pa_output_bias_o,
    .fb_divider_o, .tx_bit_o, .ask_gate_o);
  txbb_dac_model txbb_dac_model_i (.clk_sys_i, .i_sample_i(i_sample_o),
    .q_sample_i(q_sample_o), .active_o(active));
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic gap(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_sys_i);
    sfr_wr_i = 1'b1;
    sfr_addr_i = a;
    sfr_wdata_i = d;
    @(negedge clk_sys_i);
    sfr_wr_i = 1'b0;
  endtask
  task automatic rdreg(input logic [7:0] a);
    @(negedge clk_sys_i);
    sfr_rd_i = 1'b1;
    sfr_addr_i = a;
    @(negedge clk_sys_i);
    sfr_rd_i = 1'b0;
    rd = sfr_rdata_o;
  endtask
  // period 16, half period negated, quarter period i/q
  task automatic wave(input logic pol);
    logic [8:0] n;
    gap(8);
    for (int k = 0; k < 17; k++) begin
      iw[k] = i_sample_o;
      qw[k] = q_sample_o;
      @(negedge clk_sys_i);
    end
    n = -iw[0];
    chk({15'h0, active}, 16'h0001);
    chk({7'h0, iw[16]}, {7'h0, iw[0]});
    chk({7'h0, iw[8]}, {7'h0, n});
    if (pol) chk({7'h0, iw[4]}, {7'h0, qw[0]});
    else chk({7'h0, qw[4]}, {7'h0, iw[0]});
  endtask
  task automatic t_reset;
    reset_i = 1'b1;
    gap(16);
    reset_i = 1'b0;
    gap(1);
    chk({pa_supply_on_o, pre_amp_current_o, pa_output_bias_o,
      fb_divider_o}, 16'h0010);
    chk({15'h0, active}, 16'h0000);
  endtask
  task automatic t_ctrl;
    for (int c = 0; c < 4; c++) begin
      wr(8'hf1, {~c[1], 1'b0, c[1], 4'h0, c[0]});
      gap(2);
      chk({13'h0, pa_supply_on_o, pre_amp_current_o},
        {13'h0, ~c[1], c[1:0]});
    end
    wr(8'hf2, 8'h5a);
    wr(8'hc2, 8'h00);
    gap(2);
    chk({3'h0, pa_output_bias_o, fb_divider_o}, 16'h0b56);
    wr(8'hc2, 8'h80);
    gap(2);
    chk({11'h0, fb_divider_o}, 16'h0010);
  endtask
  task automatic t_state;
    rdreg(8'heb);
    chk({8'h0, rd}, 16'h0040);
    rdreg(8'h00);
    chk({8'h0, rd}, 16'h0000);
  endtask
  // ask ignores the unloaded ram; polarity swaps i and q
  task automatic t_ask;
    wr(8'hd1, 8'h40);
    wr(8'hd3, 8'h18);
    wave(1'b0);
    wr(8'hd3, 8'h38);
    wave(1'b1);
  endtask
  // ram filled with one word; a write without access is refused
  task automatic t_fsk;
    wr(8'hd3, 8'h04);
    for (int k = 0; k < 64; k++) begin
      wr(8'hca, k[7:0]);
      wr(8'hc9, 8'h80);
    end
    wr(8'hd3, 8'h00);
    wr(8'hca, 8'h05);
    wr(8'hc9, 8'h11);
    wr(8'hca, 8'h08); // refused word lies inside the sweep
    wr(8'hd2, 8'h01);
    wr(8'hd1, 8'h20);
    wr(8'hd3, 8'h10);
    wave(1'b0);
    wr(8'hd3, 8'h00);
    gap(8);
    chk({15'h0, active}, 16'h0000);
  endtask
  // fsk byte then ask byte, 16 clocks a bit; gate follows bit in ask
  task automatic t_shift;
    int n;
    logic [15:0] w;
    logic b, g;
    w = 16'ha53c;
    wr(8'hd3, 8'h12);
    wr(8'hcb, w[15:8]);
    rdreg(8'heb);
    chk({8'h0, rd}, 16'h00c0);
    n = 0;
    while (rd[7] === 1'b1 && n < 500) begin
      rdreg(8'heb);
      n++;
    end
    chk({15'h0, rd[7]}, 16'h0000);
    if (n < 500) begin
      gap(8);
      for (int k = 0; k < 16; k++) begin
        b = w[15 - k];
        g = (k > 7) ? b : 1'b0;
        chk({14'h0, tx_bit_o, ask_gate_o}, {14'h0, b, g});
        if (k == 7) begin
          wr(8'hcb, w[7:0]);
          wr(8'hd3, 8'h1a);
          gap(12);
        end else begin
          gap(16);
        end
      end
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    reset_i = 1'b1;
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    sfr_addr_i = 8'h00;
    sfr_wdata_i = 8'h00;
    mismatches = 0;
    num_checks = 0;
    t_reset();
    t_ctrl();
    t_reset();
    t_state();
    t_ask();
    t_fsk();
    t_shift();
    close_out();
  end
endmodule // tb_txbb_modulator
